// ===== src/pause_framer_defs.vh
/*
 * Constants of the pause framed transmit buffer: pause limits, timing,
 * buffer geometry and command terminators.
 * Assumes a 125 MHz system clock; included by its bare name.
 */
`ifndef PAUSE_FRAMER_DEFS_VH
`define PAUSE_FRAMER_DEFS_VH

// ****************************************************************
// Pause threshold
// ****************************************************************
`define PAUSE_CHARS_MIN      8'h03
`define PAUSE_CHARS_MAX      8'hFF
`define PAUSE_CHARS_RST      8'h03

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ              125
`define PAUSE_MAX_MS         170
`define PAUSE_MAX_CYC        (`PAUSE_MAX_MS * 1000 * `CLK_MHZ)
`define CHAR_BITS_RST        8'h0A
`define BIT_CYC_RST          16'h32DD

// ****************************************************************
// Buffer
// ****************************************************************
`define TXBUF_AW             10
`define TXBUF_DEPTH          1024
`define TXBUF_CTS_MARGIN     11'h040
`define STAGE_DEPTH          8
`define STAGE_AW             3

// ****************************************************************
// Command terminators
// ****************************************************************
`define CHR_CR               8'h0D
`define CHR_LF               8'h0A

`endif

// ===== src/stage_fifo.v
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module stage_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_sys_i,
    input  wire             rst_b_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    // Flush
    input  wire             flush_i
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_sys_i) begin
        if (!rst_b_i || flush_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
            always @(posedge clk_sys_i) begin
                if (push && wr_ptr_r == gi[AW-1:0]) begin
                    mem_r[gi] <= in_data_i;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ===== src/pause_framed_tx_buffer.v
/*
 * Pause framed transmit buffer: detects idle gaps on the serial transmit
 * data line, buffers received bytes for the radio and frames transmissions.
 * Assumes an external UART delivers received bytes as one-cycle strobes and
 * a radio datapath consumes bytes with valid/ready and reports preamble end.
 */
// Behaviour
// R1: No transitions on the serial input for the threshold is a pause.
// R2: Transmission ends only when buffer empty and pause seen.
// R3: Command valid only when a pause precedes its first character.
// R4: Address start character recognised only directly after a pause.
// R5: Pause threshold configurable 3 to 255 characters, resets to 3.
// R6: Pause time is character count times one character time.
// R7: Pause detection time never exceeds 170 ms.
// R8: In data mode, serial data starting makes the device enter transmit.
// R9: Preamble first; bytes arriving meanwhile are buffered and sent after.
// R10: Transmitter stays on until the backlog is fully sent.
// R11: Transmit buffer holds at most one kilobyte.
// R12: Terminal obeys clear-to-send to avoid overrun.
// R13: On overflow the buffer is discarded and transmission restarts.
// R14: Data received in receive mode is buffered, sent when channel free.
// R15: Command may end with CR or CR LF; pause still required.
// R16: With transmit priority, reception is aborted when terminal sends.
// R17: Clear-to-send drops when buffer nears full, returns when space.
`include "pause_framer_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module pause_framed_tx_buffer #(
    parameter PAUSE_MAX_CYC = `PAUSE_MAX_CYC
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_b_i,
    // Serial line and received bytes
    input  wire        serial_tx_data_in_i,
    input  wire        rx_byte_valid_i,
    input  wire [7:0]  rx_byte_i,
    output reg         cts_o,
    // Configuration
    input  wire [7:0]  pause_chars_i,
    input  wire [15:0] bit_cycles_i,
    input  wire [7:0]  char_bits_i,
    input  wire        data_mode_i,
    input  wire        priority_tx_i,
    input  wire        cmd_enable_i,
    input  wire [7:0]  addr_start_char_i,
    // Radio side
    input  wire        channel_busy_i,
    input  wire        preamble_done_i,
    output reg         radio_tx_o,
    output reg         preamble_start_o,
    output reg         rx_abort_o,
    output wire        tx_byte_valid_o,
    input  wire        tx_byte_ready_i,
    output wire [7:0]  tx_byte_o,
    // Status and events
    output reg         pause_o,
    output reg         host_config_command_o,
    output reg         addr_start_o,
    output reg         overflow_o
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam ST_RX       = 2'b00;
    localparam ST_PREAMBLE = 2'b01;
    localparam ST_SEND     = 2'b10;

    // ****************************************************************
    // Serial input synchroniser and pause timer
    // ****************************************************************
    reg        td_meta_r;
    reg        td_sync_r;
    reg        td_prev_r;
    reg [7:0]  pause_chars_r;
    reg [23:0] char_cyc_r;
    reg [31:0] pause_cyc_r;
    reg [31:0] idle_cnt_r;
    reg        pause_seen_r;
    wire       td_edge;

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            td_meta_r <= 1'b1;
            td_sync_r <= 1'b1;
            td_prev_r <= 1'b1;
        end else begin
            td_meta_r <= serial_tx_data_in_i;
            td_sync_r <= td_meta_r;
            td_prev_r <= td_sync_r;
        end
    end

    assign td_edge = td_sync_r ^ td_prev_r;

    // Threshold clamp, character time and capped pause length.
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            // R5: threshold reset
            pause_chars_r <= `PAUSE_CHARS_RST;
            char_cyc_r    <= 24'h000000;
            pause_cyc_r   <= 32'h00000000;
        end else begin
            // R5: threshold range clamp
            if (pause_chars_i < `PAUSE_CHARS_MIN) begin
                pause_chars_r <= `PAUSE_CHARS_MIN;
            end else begin
                pause_chars_r <= pause_chars_i;
            end
            // R6: character time product
            char_cyc_r <= bit_cycles_i * char_bits_i;
            // R7: cap at 170 ms
            if (char_cyc_r * pause_chars_r > PAUSE_MAX_CYC) begin
                pause_cyc_r <= PAUSE_MAX_CYC;
            end else begin
                pause_cyc_r <= char_cyc_r * pause_chars_r;
            end
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            idle_cnt_r <= 32'h00000000;
            pause_o    <= 1'b1;
        end else if (td_edge) begin
            // R1: any transition restarts idle
            idle_cnt_r <= 32'h00000000;
            pause_o    <= 1'b0;
        end else if (idle_cnt_r >= pause_cyc_r) begin
            pause_o <= 1'b1;
        end else begin
            idle_cnt_r <= idle_cnt_r + 32'h00000001;
        end
    end

    // ****************************************************************
    // Command and address start qualification
    // ****************************************************************
    reg       in_cmd_r;

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pause_seen_r          <= 1'b1;
            in_cmd_r              <= 1'b0;
            host_config_command_o <= 1'b0;
            addr_start_o          <= 1'b0;
        end else begin
            host_config_command_o <= 1'b0;
            addr_start_o          <= 1'b0;
            if (rx_byte_valid_i) begin
                // R1: pause frames the serial input
                pause_seen_r <= 1'b0;
                // R4: start character after a pause
                if (pause_seen_r && rx_byte_i == addr_start_char_i) begin
                    addr_start_o <= 1'b1;
                end
                // R3: command must follow a pause
                if (pause_seen_r) begin
                    in_cmd_r <= cmd_enable_i;
                end
            end else if (pause_o) begin
                // R3: command closed by the pause
                // R15: CR or CR LF endings pass
                if (!pause_seen_r && in_cmd_r) begin
                    host_config_command_o <= 1'b1;
                end
                pause_seen_r <= 1'b1;
                in_cmd_r     <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Staging FIFO feeding the 1 kB transmit buffer
    // ****************************************************************
    wire       stg_ready;
    wire       stg_valid;
    wire [7:0] stg_data;
    reg        flush_r;
    wire       buf_ready;
    reg  [1:0] radio_state_r;

    stage_fifo #(
        .WIDTH (8),
        .DEPTH (`STAGE_DEPTH),
        .AW    (`STAGE_AW)
    ) u_stage (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (rx_byte_valid_i),
        .in_ready_o  (stg_ready),
        .in_data_i   (rx_byte_i),
        .out_valid_o (stg_valid),
        .out_ready_i (buf_ready),
        .out_data_o  (stg_data),
        .flush_i     (flush_r)
    );

    reg [7:0]           buf_mem_r [0:`TXBUF_DEPTH-1];
    reg [`TXBUF_AW-1:0] wr_ptr_r;
    reg [`TXBUF_AW-1:0] rd_ptr_r;
    reg [`TXBUF_AW:0]   count_r;
    reg [7:0]           tx_byte_r;
    reg                 tx_valid_r;
    wire                buf_push;
    wire                buf_pop;
    wire                buf_empty;
    wire                ovf;

    // R11: 1 kB capacity
    assign buf_ready = ~count_r[`TXBUF_AW];
    assign buf_push  = stg_valid & buf_ready;
    assign buf_empty = (count_r == {(`TXBUF_AW+1){1'b0}});
    assign ovf       = rx_byte_valid_i & ~stg_ready;
    assign buf_pop   = ~buf_empty & (radio_state_r == ST_SEND)
                       & (~tx_valid_r | tx_byte_ready_i);
    assign tx_byte_valid_o = tx_valid_r;
    assign tx_byte_o       = tx_byte_r;

    always @(posedge clk_sys_i) begin
        if (buf_push) begin
            buf_mem_r[wr_ptr_r] <= stg_data;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rst_b_i || flush_r) begin
            wr_ptr_r   <= {`TXBUF_AW{1'b0}};
            rd_ptr_r   <= {`TXBUF_AW{1'b0}};
            count_r    <= {(`TXBUF_AW+1){1'b0}};
            tx_valid_r <= 1'b0;
            tx_byte_r  <= 8'h00;
        end else begin
            if (buf_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (buf_pop) begin
                rd_ptr_r   <= rd_ptr_r + 1'b1;
                tx_byte_r  <= buf_mem_r[rd_ptr_r];
                tx_valid_r <= 1'b1;
            end else if (tx_byte_ready_i) begin
                tx_valid_r <= 1'b0;
            end
            if (buf_push && !buf_pop) begin
                count_r <= count_r + 1'b1;
            end else if (buf_pop && !buf_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // R17: clear-to-send hysteresis
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cts_o <= 1'b1;
        end else if (count_r >= `TXBUF_DEPTH - `TXBUF_CTS_MARGIN) begin
            cts_o <= 1'b0;
        end else if (count_r < `TXBUF_DEPTH - 2 * `TXBUF_CTS_MARGIN) begin
            cts_o <= 1'b1;
        end
    end

    // ****************************************************************
    // Radio state machine
    // ****************************************************************
    reg [1:0] radio_state_nxt;
    wire      have_data;

    assign have_data = ~buf_empty | stg_valid | tx_valid_r;

    always @* begin
        radio_state_nxt = radio_state_r;
        case (radio_state_r)
            ST_RX: begin
                // R8: data starts transmit
                // R14: wait for free channel
                // R16: transmit priority aborts reception
                if (data_mode_i && have_data && (priority_tx_i || !channel_busy_i)) begin
                    radio_state_nxt = ST_PREAMBLE;
                end
            end
            ST_PREAMBLE: begin
                // R9: buffer during preamble
                if (preamble_done_i) begin
                    radio_state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                // R2: drained and paused
                // R10: stay on for backlog
                if (!have_data && pause_o) begin
                    radio_state_nxt = ST_RX;
                end
            end
            default: begin
                radio_state_nxt = ST_RX;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            radio_state_r    <= ST_RX;
            radio_tx_o       <= 1'b0;
            preamble_start_o <= 1'b0;
            rx_abort_o       <= 1'b0;
            overflow_o       <= 1'b0;
            flush_r          <= 1'b0;
        end else begin
            preamble_start_o <= 1'b0;
            rx_abort_o       <= 1'b0;
            overflow_o       <= 1'b0;
            flush_r          <= 1'b0;
            if (ovf) begin
                // R13: discard and restart
                flush_r       <= 1'b1;
                overflow_o    <= 1'b1;
                radio_state_r <= ST_RX;
                radio_tx_o    <= 1'b0;
            end else begin
                radio_state_r <= radio_state_nxt;
                radio_tx_o    <= (radio_state_nxt != ST_RX);
                if (radio_state_r == ST_RX && radio_state_nxt == ST_PREAMBLE) begin
                    preamble_start_o <= 1'b1;
                    rx_abort_o       <= channel_busy_i;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== bench/pause_framer_assertions.sv
/*
 * Checker for the pause framed transmit buffer, bound to its top module.
 * Assumes one clock and the synchronous active-low reset of the design.
 */
`timescale 1ns/10ps
`default_nettype none

module pause_framer_checker #(
    parameter PAUSE_MAX_CYC = 2000
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic        serial_tx_data_in_i,
    input wire logic        rx_byte_valid_i,
    input wire logic [7:0]  pause_chars_i,
    input wire logic [15:0] bit_cycles_i,
    input wire logic [7:0]  char_bits_i,
    input wire logic        data_mode_i,
    input wire logic        priority_tx_i,
    input wire logic        cmd_enable_i,
    input wire logic        channel_busy_i,
    input wire logic        preamble_done_i,
    input wire logic        cts_o,
    input wire logic        radio_tx_o,
    input wire logic        preamble_start_o,
    input wire logic        rx_abort_o,
    input wire logic        tx_byte_valid_o,
    input wire logic        pause_o,
    input wire logic        host_config_command_o,
    input wire logic        overflow_o
);
    logic        ser_q_r;
    logic        in_pre_r;
    logic [31:0] quiet_r;
    logic [31:0] thr;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // ****************************************************************
    // Quiet line counter and expected threshold
    // ****************************************************************
    always_comb begin
        thr = 32'(bit_cycles_i) * 32'(char_bits_i) * 32'((pause_chars_i < 8'h03) ? 8'h03 : pause_chars_i);
        if (thr > PAUSE_MAX_CYC) begin
            thr = PAUSE_MAX_CYC;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        ser_q_r  <= serial_tx_data_in_i;
        quiet_r  <= (!rst_b_i || serial_tx_data_in_i != ser_q_r) ? 32'h0 : quiet_r + 32'h1;
        in_pre_r <= rst_b_i && (preamble_start_o || (in_pre_r && !preamble_done_i));
    end

    AST_RST_VAL: assert property ($rose(rst_b_i) |-> cts_o && pause_o && !radio_tx_o)
        else $error("outputs wrong after reset");
    AST_PAUSE_FALL: assert property ($changed(serial_tx_data_in_i) |-> ##[1:5] !pause_o)
        else $error("pause kept after line edge");
    AST_PAUSE_MIN: assert property ($rose(pause_o) |-> quiet_r >= thr)
        else $error("pause before threshold");
    AST_PAUSE_CAP: assert property (quiet_r > PAUSE_MAX_CYC + 8 |-> pause_o)
        else $error("pause later than cap");
    AST_TX_START: assert property (rx_byte_valid_i && data_mode_i && !cmd_enable_i &&
        !channel_busy_i && !radio_tx_o |-> ##[1:4] radio_tx_o)
        else $error("transmitter not started");
    AST_PREAMBLE: assert property ($rose(radio_tx_o) |-> ##[0:1] preamble_start_o)
        else $error("no preamble at start");
    AST_HOLD_PRE: assert property (in_pre_r |-> !tx_byte_valid_o)
        else $error("byte sent during preamble");
    AST_TX_END: assert property ($fell(radio_tx_o) |->
        (pause_o && !tx_byte_valid_o) || overflow_o)
        else $error("transmitter off too early");
    AST_ABORT: assert property (rx_abort_o |-> priority_tx_i && channel_busy_i && preamble_start_o)
        else $error("abort without cause");
    AST_PRIO_RX: assert property ((!priority_tx_i && channel_busy_i && !radio_tx_o) [*3]
        |=> !radio_tx_o)
        else $error("sent over busy channel");
    AST_OVF_OFF: assert property (overflow_o |-> ##[0:2] !radio_tx_o)
        else $error("transmitter on after overflow");
    AST_CMD_PAUSE: assert property (host_config_command_o |-> pause_o && cmd_enable_i)
        else $error("command without pause");
endmodule

bind pause_framed_tx_buffer pause_framer_checker #(.PAUSE_MAX_CYC(PAUSE_MAX_CYC)) u_chk (.*);

`default_nettype wire

// ===== bench/dte_model.sv
/*
 * Terminal model: sends 10-bit serial characters and the matching byte strobe.
 * Assumes tasks are called just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module dte_model (
    input  wire logic        clk_sys_i,
    input  wire logic        cts_i,
    input  wire logic [15:0] bit_cycles_i,
    output var  logic        serial_o,
    output var  logic        byte_valid_o,
    output var  logic [7:0]  byte_o
);
    initial begin
        serial_o     = 1'b1;
        byte_valid_o = 1'b0;
        byte_o       = 8'h00;
    end

    task automatic send(input logic [7:0] b);
        logic [9:0] sh;
        int         i;
        int         k;
        sh = {1'b1, b, 1'b0};
        while (!cts_i) @(posedge clk_sys_i);
        for (i = 0; i < 10; i++) begin
            serial_o <= sh[i];
            for (k = 0; k < bit_cycles_i; k++) @(posedge clk_sys_i);
        end
        byte_o       <= b;
        byte_valid_o <= 1'b1;
        @(posedge clk_sys_i);
        byte_valid_o <= 1'b0;
        byte_o       <= ~b;
    endtask

    task automatic flood(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            byte_valid_o <= 1'b1;
            byte_o       <= i[7:0];
            @(posedge clk_sys_i);
        end
        byte_valid_o <= 1'b0;
        byte_o       <= ~byte_o;
    endtask
endmodule

`default_nettype wire

// ===== bench/testbench.sv
/*
 * Self-checking bench of the pause framed transmit buffer.
 * Assumes the design constants header on the include path.
 */
`include "pause_framer_defs.vh"
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", nm, e, s); end end

module testbench;
    localparam int MAXC = 2000;
    localparam int CH   = 40;

    logic       clk_sys_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       serial, rx_v, cts_o, radio_tx_o, pre_st, abort_o, tx_v, pause_o, cmd_o, addr_o, ovf_o;
    logic [7:0] rx_b, tx_b;
    logic [7:0] pause_chars_i;
    logic       data_mode_i, priority_tx_i, cmd_enable_i, channel_busy_i, preamble_done_i;
    logic       tx_byte_ready_i;
    logic       ser_q, cts_q;
    logic [7:0] got[$];
    int         pre_cnt, quiet, n_bytes, cts_at, ovf_at, n_abort, n_addr, n_cmd;
    int         checked = 0;
    int         miscompares = 0;
    logic [7:0] row_chr[4] = '{8'h00, 8'h03, 8'h07, 8'hFF};
    int         row_exp[4] = '{3 * CH, 3 * CH, 7 * CH, MAXC};

    always #4 clk_sys_i = ~clk_sys_i;

    pause_framed_tx_buffer #(.PAUSE_MAX_CYC(MAXC)) DUT (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .serial_tx_data_in_i(serial),
        .rx_byte_valid_i(rx_v), .rx_byte_i(rx_b), .cts_o(cts_o), .pause_chars_i(pause_chars_i),
        .bit_cycles_i(16'h0004), .char_bits_i(8'h0A), .data_mode_i(data_mode_i),
        .priority_tx_i(priority_tx_i), .cmd_enable_i(cmd_enable_i), .addr_start_char_i(8'h7E),
        .channel_busy_i(channel_busy_i), .preamble_done_i(preamble_done_i), .radio_tx_o(radio_tx_o),
        .preamble_start_o(pre_st), .rx_abort_o(abort_o), .tx_byte_valid_o(tx_v),
        .tx_byte_ready_i(tx_byte_ready_i), .tx_byte_o(tx_b), .pause_o(pause_o),
        .host_config_command_o(cmd_o), .addr_start_o(addr_o), .overflow_o(ovf_o));

    dte_model DTE (.clk_sys_i(clk_sys_i), .cts_i(cts_o), .bit_cycles_i(16'h0004),
        .serial_o(serial), .byte_valid_o(rx_v), .byte_o(rx_b));

    // ****************************************************************
    // Radio side responder and monitors
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        preamble_done_i <= (pre_cnt == 1);
        pre_cnt <= pre_st ? 100 : (pre_cnt != 0) ? pre_cnt - 1 : 0;
        quiet <= (serial !== ser_q) ? 0 : quiet + 1;
        ser_q <= serial;
        cts_q <= cts_o;
        if (rst_b_i) begin
            n_bytes <= n_bytes + rx_v;
            n_abort <= n_abort + abort_o;
            n_addr  <= n_addr + addr_o;
            n_cmd   <= n_cmd + cmd_o;
            if (cts_q && !cts_o) cts_at <= n_bytes;
            if (ovf_o) ovf_at <= n_bytes;
            if (tx_v && tx_byte_ready_i) got.push_back(tx_b);
        end
    end

    task automatic wait_on(input string nm, ref logic s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && s !== v; k++) @(posedge clk_sys_i);
        `CHK(nm, v, s)
    endtask

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys_i);
        miscompares++;
        conclude();
    end

    initial begin
        int i, j, g0, a0, c0, b0;
        {pre_cnt, quiet, n_bytes, cts_at, ovf_at, n_abort, n_addr, n_cmd} = '0;
        {data_mode_i, priority_tx_i, cmd_enable_i, channel_busy_i, tx_byte_ready_i} <= 5'h19;
        pause_chars_i <= 8'h03;
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        `CHK("cts", 1'b1, cts_o)
        `CHK("pause", 1'b1, pause_o)
        `CHK("radio_tx", 1'b0, radio_tx_o)
        for (i = 0; i < 4; i++) begin
            pause_chars_i <= row_chr[i];
            repeat (4) @(posedge clk_sys_i);
            DTE.send(8'h55);
            wait_on("pause", pause_o, 1'b1, 2500);
            `CHK("quiet_lo", 1'b1, quiet >= row_exp[i])
            `CHK("quiet_hi", 1'b1, quiet <= row_exp[i] + 10)
            wait_on("radio_off", radio_tx_o, 1'b0, 300);
        end
        pause_chars_i <= 8'h03;
        tx_byte_ready_i <= 1'b0;
        g0 = got.size();
        for (i = 0; i < 3; i++) DTE.send(8'hA1 + 8'h11 * i[7:0]);
        repeat (200) @(posedge clk_sys_i);
        `CHK("pause_stall", 1'b1, pause_o)
        `CHK("tx_backlog", 1'b1, radio_tx_o)
        tx_byte_ready_i <= 1'b1;
        wait_on("radio_off", radio_tx_o, 1'b0, 300);
        for (i = 0; i < 3; i++) `CHK("tx_byte", 8'hA1 + 8'h11 * i[7:0], got[g0 + i])
        channel_busy_i <= 1'b1;
        a0 = n_abort;
        DTE.send(8'h11);
        repeat (6) @(posedge clk_sys_i);
        `CHK("abort", 1, n_abort - a0)
        channel_busy_i <= 1'b0;
        wait_on("radio_off", radio_tx_o, 1'b0, 400);
        priority_tx_i <= 1'b0;
        channel_busy_i <= 1'b1;
        g0 = got.size();
        data_mode_i <= 1'b0;
        DTE.send(8'h22);
        repeat (150) @(posedge clk_sys_i);
        `CHK("no_data_mode", 1'b0, radio_tx_o)
        data_mode_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        `CHK("held_rx", 1'b0, radio_tx_o)
        channel_busy_i <= 1'b0;
        wait_on("free_tx", radio_tx_o, 1'b1, 10);
        wait_on("radio_off", radio_tx_o, 1'b0, 400);
        `CHK("held_byte", 8'h22, got[g0])
        priority_tx_i <= 1'b1;
        a0 = n_addr;
        c0 = n_cmd;
        DTE.send(8'h7E);
        DTE.send(8'h7E);
        wait_on("radio_off", radio_tx_o, 1'b0, 400);
        `CHK("addr", 1, n_addr - a0)
        `CHK("no_cmd", 0, n_cmd - c0)
        cmd_enable_i <= 1'b1;
        for (j = 0; j < 2; j++) begin
            c0 = n_cmd;
            DTE.send(8'h53);
            DTE.send(`CHR_CR);
            if (j == 1) DTE.send(`CHR_LF);
            wait_on("pause", pause_o, 1'b1, 300);
            repeat (4) @(posedge clk_sys_i);
            `CHK("cmd", 1, n_cmd - c0)
            wait_on("radio_off", radio_tx_o, 1'b0, 400);
        end
        cmd_enable_i <= 1'b0;
        tx_byte_ready_i <= 1'b0;
        b0 = n_bytes;
        DTE.flood(1040);
        repeat (4) @(posedge clk_sys_i);
        `CHK("cts_drop", 1'b1, cts_at - b0 >= 958 && cts_at - b0 <= 972)
        `CHK("ovf_at", 1'b1, ovf_at - b0 >= 1025 && ovf_at - b0 <= 1040)
        `CHK("cts_back", 1'b1, cts_o)
        g0 = got.size();
        tx_byte_ready_i <= 1'b1;
        wait_on("radio_off", radio_tx_o, 1'b0, 600);
        `CHK("discard", 1'b1, got.size() - g0 < 16)
        conclude();
    end
endmodule

`default_nettype wire
